// *** verilog/pin_pkg.sv ***
/*
 * shared constants and types for the flag, interrupt request and timer pin block.
 * assumes a single 250 MHz clock and a synchronous active-low reset.
 */
package pin_pkg;
    localparam int          NUM_FLAGS      = 4;
    localparam int          NUM_IRQS       = 4;
    localparam int          CLK_MHZ        = 250;
    // pulse length of the timer expired output, in system clock cycles
    localparam logic [2:0]  TIMER_PULSE_CYC = 3'h4;
    localparam logic [2:0]  PULSE_CNT_ZERO  = 3'h0;
    localparam logic [2:0]  PULSE_CNT_ONE   = 3'h1;

    // avalon register offsets (byte addresses, one word each)
    localparam logic [4:0]  OFS_FLAG_DIR   = 5'h00;
    localparam logic [4:0]  OFS_FLAG_OUT   = 5'h04;
    localparam logic [4:0]  OFS_FLAG_IN    = 5'h08;
    localparam logic [4:0]  OFS_IRQ_CTRL   = 5'h0c;
    localparam logic [4:0]  OFS_IRQ_STATUS = 5'h10;
    localparam logic [4:0]  OFS_IRQ_MASK   = 5'h14;
    localparam logic [4:0]  OFS_STRAP      = 5'h18;

    // field positions in the interrupt control word
    localparam int          IRQ_ENABLE_LSB = 0;
    localparam int          IRQ_EDGE_LSB   = 4;

    localparam logic [3:0]  FLAG_DIR_RESET = 4'h0;
    localparam logic [31:0] UNMAPPED_READ  = 32'h00000000;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_ANSWER = 2'b01
    } bus_state_t;
endpackage

// *** verilog/sync_if.sv ***
/*
 * interface carrying raw pins into the synchroniser and clean levels back.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface sync_if;
    logic [7:0] raw_in;
    logic [7:0] sync_out;
    modport source (output raw_in, input sync_out);
    modport sink   (input raw_in, output sync_out);
endinterface

// *** verilog/input_sync.sv ***
/*
 * two-stage synchroniser for the asynchronous flag and interrupt pins.
 * assumes one clock; the first stage feeds only the second.
 */
`timescale 1ns/10ps
module input_sync
(
    input  wire logic clk,
    input  wire logic reset_n,
    sync_if.sink      port_s
);
    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] stable;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb
    begin
        state_next        = state_reg;
        state_next.meta   = port_s.raw_in;
        state_next.stable = state_reg.meta;
        if (!reset_n)
        begin
            state_next = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        state_reg <= state_next;
    end

    assign port_s.sync_out = state_reg.stable;
endmodule

// *** verilog/flag_irq_timer_pins.sv ***
/*
 * flag pins, external interrupt requests and timer zero expired pulse, with an avalon register slave.
 * register words (low bits used, the rest read as zero):
 *   flag direction, one bit per pin, 1 = output
 *   flag output values
 *   flag input levels after synchronisation, read only
 *   interrupt control, enable bits in the low nibble, edge select bits in the next
 *   interrupt status, write one to clear: request lines, then timer expiry
 *   interrupt mask, same layout as status
 *   strap word, read only: timer pin strap, then interrupt boot strap
 * bus timing: a request is taken while idle and answered one cycle later with waitrequest low;
 * a write lands at that answering edge, never earlier.
 * the timer pin stays undriven through reset and one cycle after it, so the strap can be read.
 * assumes pins are asynchronous to clk, core acknowledges edge interrupts per line,
 * and the board holds the strap level on the timer pin while it is undriven, through reset and one cycle after.
// How it works
// - each flag pin level, synchronised, goes to the sequencer as a condition.
// - every flag pin has its own direction bit, input or output.
// - reset makes all flags inputs with drivers off.
// - an enabled, asserted interrupt request raises the core interrupt.
// - each request line chooses edge or level detection.
// - requests are disabled after reset unless the boot strap selects interrupt boot.
// - each timer zero expiry drives a four-cycle output pulse.
// - the timer pin is sampled as a strap during reset; board holds it.
 */
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module flag_irq_timer_pins
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  program_flag_pins_in,
    output logic      [3:0]  program_flag_pins_out,
    output logic      [3:0]  program_flag_pins_oe_n,
    input  wire logic [3:0]  interrupt_request_inputs_n,
    input  wire logic        timer_zero_expired_in,
    output logic             timer_zero_expired_output,
    output logic             timer_zero_expired_oe_n,
    input  wire logic        irq_boot_strap,
    input  wire logic        timer_zero_expire,
    input  wire logic [3:0]  irq_ack,
    output logic      [3:0]  flag_condition,
    output logic      [3:0]  core_irq_request,
    output logic             core_irq,
    output logic             strap_timer_pin,
    output logic             irq,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    typedef struct packed {
        logic [3:0]           flag_dir;
        logic [3:0]           flag_out;
        logic [3:0]           irq_enable;
        logic [3:0]           irq_edge;
        logic [3:0]           irq_prev;
        logic [3:0]           irq_pending;
        logic [3:0]           request;
        logic                 core_irq;
        logic [3:0]           flag_cond;
        logic [2:0]           pulse_cnt;
        logic                 pulse_out;
        logic                 strap_val;
        logic                 strap_boot;
        logic                 in_reset;
        logic [4:0]           status;
        logic [4:0]           mask;
        logic                 irq;
        pin_pkg::bus_state_t  bus_state;
        logic [31:0]          rdata;
        logic [3:0]           flag_oe_n;
        logic                 waitreq;
    } pin_state_t;

    pin_state_t state_reg;
    pin_state_t state_next;
    sync_if     sync_port ();

    assign sync_port.raw_in = {~interrupt_request_inputs_n, program_flag_pins_in};

    input_sync sync_inst
    (
        .clk     (clk),
        .reset_n (reset_n),
        .port_s  (sync_port.sink)
    );

    // unmapped offsets answer zero rather than an error, so a stray read never stalls the bus
    function automatic logic [31:0] read_mux(input pin_state_t s, input logic [4:0] addr);
        logic [31:0] d;
        d = pin_pkg::UNMAPPED_READ;
        case (addr)
            pin_pkg::OFS_FLAG_DIR:
            begin
                d[3:0] = s.flag_dir;
            end
            pin_pkg::OFS_FLAG_OUT:
            begin
                d[3:0] = s.flag_out;
            end
            pin_pkg::OFS_FLAG_IN:
            begin
                d[3:0] = s.flag_cond;
            end
            pin_pkg::OFS_IRQ_CTRL:
            begin
                d[7:0] = {s.irq_edge, s.irq_enable};
            end
            pin_pkg::OFS_IRQ_STATUS:
            begin
                d[4:0] = s.status;
            end
            pin_pkg::OFS_IRQ_MASK:
            begin
                d[4:0] = s.mask;
            end
            pin_pkg::OFS_STRAP:
            begin
                d[1:0] = {s.strap_boot, s.strap_val};
            end
            default:
            begin
                d = pin_pkg::UNMAPPED_READ;
            end
        endcase
        return d;
    endfunction

    // a new expiry restarts the full count, otherwise count down and rest at zero
    function automatic logic [2:0] pulse_step(input logic [2:0] cnt, input logic start);
        logic [2:0] n;
        n = cnt;
        if (start)
        begin
            n = pin_pkg::TIMER_PULSE_CYC;
        end
        else if (cnt != pin_pkg::PULSE_CNT_ZERO)
        begin
            n = cnt - pin_pkg::PULSE_CNT_ONE;
        end
        return n;
    endfunction

    // register writes; read-only and unmapped offsets leave the state alone
    function automatic pin_state_t apply_write(input pin_state_t  s,
                                               input logic [4:0]  addr,
                                               input logic [31:0] data);
        pin_state_t n;
        n = s;
        case (addr)
            pin_pkg::OFS_FLAG_DIR:
            begin
                n.flag_dir = data[3:0];
            end
            pin_pkg::OFS_FLAG_OUT:
            begin
                n.flag_out = data[3:0];
            end
            pin_pkg::OFS_IRQ_CTRL:
            begin
                n.irq_enable = data[pin_pkg::IRQ_ENABLE_LSB +: 4];
                n.irq_edge   = data[pin_pkg::IRQ_EDGE_LSB +: 4];
            end
            pin_pkg::OFS_IRQ_STATUS:
            begin
                n.status = s.status & ~data[4:0];
            end
            pin_pkg::OFS_IRQ_MASK:
            begin
                n.mask = data[4:0];
            end
            default:
            begin
                n = s;
            end
        endcase
        return n;
    endfunction

    always_comb
    begin
        logic [3:0] sync_irq;
        logic [3:0] rise;
        logic [4:0] events;
        logic       wr_hit;
        logic       pulse_start;
        sync_irq    = sync_port.sync_out[7:4];
        rise        = '0;
        events      = '0;
        wr_hit      = 1'b0;
        pulse_start = 1'b0;
        state_next  = state_reg;

        // flags feed the sequencer whatever their direction, so a driven output can be tested too
        state_next.flag_cond = sync_port.sync_out[3:0];
        state_next.irq_prev  = sync_irq;
        rise = sync_irq & ~state_reg.irq_prev;

        // an edge in the ack cycle wins over the ack; a disabled line drops what it held
        for (int i = 0; i < pin_pkg::NUM_IRQS; i++)
        begin
            if (state_reg.irq_enable[i] && state_reg.irq_edge[i])
            begin
                state_next.irq_pending[i] = (state_reg.irq_pending[i] & ~irq_ack[i]) | rise[i];
                state_next.request[i]     = state_next.irq_pending[i];
            end
            else if (state_reg.irq_enable[i])
            begin
                state_next.irq_pending[i] = 1'b0;
                state_next.request[i]     = sync_irq[i];
            end
            else
            begin
                state_next.irq_pending[i] = 1'b0;
                state_next.request[i]     = 1'b0;
            end
        end
        state_next.core_irq = |state_next.request;

        // pulse held for the full count; an expiry mid-pulse restarts it
        pulse_start          = timer_zero_expire;
        state_next.pulse_cnt = pulse_step(state_reg.pulse_cnt, pulse_start);
        state_next.pulse_out = pulse_start |
            (state_reg.pulse_cnt > pin_pkg::PULSE_CNT_ONE);

        // first cycle out of reset: strap latched, boot option applied
        state_next.in_reset = 1'b0;
        if (state_reg.in_reset)
        begin
            state_next.strap_val  = timer_zero_expired_in;
            state_next.strap_boot = irq_boot_strap;
            state_next.irq_enable = {pin_pkg::NUM_IRQS{irq_boot_strap}};
        end

        // status records enabled line edges in either mode, plus every timer expiry
        events = {pulse_start, rise & state_reg.irq_enable};

        state_next.bus_state = pin_pkg::BUS_IDLE;
        case (state_reg.bus_state)
            pin_pkg::BUS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    state_next.bus_state = pin_pkg::BUS_ANSWER;
                    // read data are captured here and stand through the answering cycle
                    state_next.rdata     = read_mux(state_reg, avs_address);
                end
            end
            pin_pkg::BUS_ANSWER:
            begin
                // the master still holds its request here; this edge completes it
                state_next.bus_state = pin_pkg::BUS_IDLE;
                wr_hit               = avs_write;
            end
            default:
            begin
                state_next.bus_state = pin_pkg::BUS_IDLE;
            end
        endcase

        state_next.status = state_reg.status;
        if (wr_hit)
        begin
            state_next = apply_write(state_next, avs_address, avs_writedata);
        end
        state_next.status = state_next.status | events;
        state_next.irq    = |(state_next.status & state_next.mask);

        if (!reset_n)
        begin
            state_next            = '0;
            state_next.flag_dir   = pin_pkg::FLAG_DIR_RESET;
            state_next.irq_enable = '0;
            state_next.in_reset   = 1'b1;
            state_next.bus_state  = pin_pkg::BUS_IDLE;
        end

        // registered copies, so the pin enables and waitrequest leave straight from flip-flops
        state_next.flag_oe_n = ~state_next.flag_dir;
        state_next.waitreq   = (state_next.bus_state != pin_pkg::BUS_ANSWER);
    end

    // synchronous reset only: state_next already carries the reset values
    always_ff @(posedge clk)
    begin
        state_reg <= state_next;
    end

    assign program_flag_pins_out      = state_reg.flag_out;
    assign program_flag_pins_oe_n     = state_reg.flag_oe_n;
    assign timer_zero_expired_output  = state_reg.pulse_out;
    assign timer_zero_expired_oe_n    = state_reg.in_reset;
    assign flag_condition             = state_reg.flag_cond;
    assign core_irq_request           = state_reg.request;
    assign core_irq                   = state_reg.core_irq;
    assign strap_timer_pin            = state_reg.strap_val;
    assign irq                        = state_reg.irq;
    assign avs_readdata               = state_reg.rdata;
    assign avs_waitrequest            = state_reg.waitreq;
endmodule

// *** testbench/pin_checker.sv ***
/* checker for the flag, request and timer pin block: pulse, straps, sync, bus answer.
   assumes it is bound into flag_irq_timer_pins and sees only its ports. */
`timescale 1ns/10ps
module pin_checker
(
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic [3:0]  program_flag_pins_in,
    input wire logic [3:0]  program_flag_pins_oe_n,
    input wire logic        timer_zero_expire,
    input wire logic        timer_zero_expired_output,
    input wire logic        timer_zero_expired_oe_n,
    input wire logic        timer_zero_expired_in,
    input wire logic        strap_timer_pin,
    input wire logic [3:0]  flag_condition,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_pulse_hi;
        timer_zero_expire |=> timer_zero_expired_output [*4];
    endproperty
    a_pulse_hi: assert property (p_pulse_hi) else $error("timer pulse too short");
    property p_pulse_end;
        timer_zero_expire ##1 (!timer_zero_expire) [*4] |=> !timer_zero_expired_output;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("timer pulse too long");
    property p_oe_reset;
        $rose(reset_n) |-> program_flag_pins_oe_n == 4'hf && timer_zero_expired_oe_n;
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("pins driven after reset");
    property p_strap;
        $rose(reset_n) |=> strap_timer_pin == $past(timer_zero_expired_in);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not latched");
    // stable for four edges so a two or three stage path has settled
    property p_flag_sync;
        (reset_n && $stable(program_flag_pins_in)) [*4] |-> flag_condition == program_flag_pins_in;
    endproperty
    a_flag_sync: assert property (p_flag_sync) else $error("flag condition wrong");
    property p_dir_write;
        avs_write && !avs_waitrequest && avs_address == pin_pkg::OFS_FLAG_DIR
            |=> program_flag_pins_oe_n == ~$past(avs_writedata[3:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not applied");
    property p_dir_hold;
        !(avs_write && avs_address == pin_pkg::OFS_FLAG_DIR) |=> $stable(program_flag_pins_oe_n);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction changed alone");
    property p_wait_ans;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("bus answer late");
    property p_wait_idle;
        !(avs_read || avs_write) |=> avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("bus answer without request");
    c_pulse: cover property (timer_zero_expire);
    c_dir: cover property (avs_write && avs_address == pin_pkg::OFS_FLAG_DIR);
    c_strap: cover property ($rose(reset_n) ##1 strap_timer_pin);
endmodule
bind flag_irq_timer_pins pin_checker pin_checker_inst (.clk(clk), .reset_n(reset_n),
    .program_flag_pins_in(program_flag_pins_in), .program_flag_pins_oe_n(program_flag_pins_oe_n),
    .timer_zero_expire(timer_zero_expire), .timer_zero_expired_output(timer_zero_expired_output),
    .timer_zero_expired_oe_n(timer_zero_expired_oe_n), .timer_zero_expired_in(timer_zero_expired_in),
    .strap_timer_pin(strap_timer_pin), .flag_condition(flag_condition), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest));

// *** testbench/board_model.sv ***
/* board side of the pins: flag drivers with pull-down, request pins with pull-up, timer strap.
   assumes the bench steers it by level controls. */
`timescale 1ns/10ps
module board_model
(
    input  wire logic [3:0] flag_oe_n,
    input  wire logic [3:0] flag_out,
    input  wire logic [3:0] drive,
    input  wire logic [3:0] value,
    input  wire logic [3:0] assert_req,
    input  wire logic       timer_oe_n,
    input  wire logic       timer_out,
    input  wire logic       strap,
    output logic      [3:0] flag_level,
    output logic      [3:0] req_n,
    output logic            timer_level
);
    // undriven flags fall to the pull-down
    assign flag_level = (~flag_oe_n & flag_out) | (flag_oe_n & drive & value);
    assign req_n = ~assert_req;
    // strap held while the device leaves the pin undriven
    assign timer_level = timer_oe_n ? strap : timer_out;
endmodule

// *** testbench/tb_top.sv ***
/* self-checking bench for the pin block with board model and register bus master.
   assumes the bench alone drives clk, reset_n and the bus. */
`timescale 1ns/10ps
module tb_top;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  fo, oe_n, ia = 4'h0, drv = 4'h0, val = 4'h0, ack = 4'h0, fin, irn, fc, cir;
    logic        tin, tout, toe_n, ci, sp, irq, boot = 1'b0, strap = 1'b0, expire = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic        rd = 1'b0, wr = 1'b0, wreq;
    logic [31:0] wd = 32'h0, rdata;
    int          fails = 0, check_count = 0, cyc = 0;
    flag_irq_timer_pins flag_irq_timer_pins_inst (.clk(clk), .reset_n(reset_n), .program_flag_pins_in(fin),
        .program_flag_pins_out(fo), .program_flag_pins_oe_n(oe_n), .interrupt_request_inputs_n(irn),
        .timer_zero_expired_in(tin), .timer_zero_expired_output(tout), .timer_zero_expired_oe_n(toe_n),
        .irq_boot_strap(boot), .timer_zero_expire(expire), .irq_ack(ack), .flag_condition(fc),
        .core_irq_request(cir), .core_irq(ci), .strap_timer_pin(sp), .irq(irq), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq));
    board_model board_model_inst (.flag_oe_n(oe_n), .flag_out(fo), .drive(drv), .value(val),
        .assert_req(ia), .timer_oe_n(toe_n), .timer_out(tout), .strap(strap), .flag_level(fin),
        .req_n(irn), .timer_level(tin));
    initial
    begin
        forever #2 clk = ~clk;
    end
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            $display("ERROR %0t: timeout", $time);
            end_sim();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("ERROR %0t: %s", $time, m);
        end
    endtask
    // holds the request until waitrequest is sampled low at a rising edge
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task t_defaults;
        logic [31:0] q;
        chk(oe_n === 4'hf, "flags driven");
        ia <= 4'hf;
        tick(6);
        chk(cir === 4'h0 && ci === 1'b0, "request live after reset");
        ia <= 4'h0;
        bus(1'b0, pin_pkg::OFS_STRAP, 32'h0, q);
        chk(q === 32'h0, "strap word");
    endtask
    task t_flags;
        logic [31:0] q;
        bus(1'b1, pin_pkg::OFS_FLAG_DIR, 32'h5, q);
        bus(1'b1, pin_pkg::OFS_FLAG_OUT, 32'h3, q);
        chk(oe_n === 4'ha, "per pin direction");
        drv <= 4'ha;
        val <= 4'ha;
        tick(1);
        chk(fc !== 4'hb, "flag passed unsynchronised");
        tick(4);
        chk(fc === 4'hb, "flag condition");
        bus(1'b0, pin_pkg::OFS_FLAG_IN, 32'h0, q);
        chk(q[3:0] === 4'hb, "flag read");
        bus(1'b1, pin_pkg::OFS_FLAG_DIR, 32'h0, q);
        drv <= 4'h0;
    endtask
    task t_irq;
        logic [31:0] q;
        bus(1'b1, pin_pkg::OFS_IRQ_CTRL, 32'h13, q);
        ia <= 4'h3;
        tick(6);
        chk(cir === 4'h3 && ci === 1'b1, "request missed");
        ia <= 4'h0;
        tick(6);
        chk(cir === 4'h1, "edge not held or level held");
        ack <= 4'h1;
        tick(1);
        ack <= 4'h0;
        tick(3);
        chk(cir === 4'h0, "pending not acknowledged");
        bus(1'b0, pin_pkg::OFS_IRQ_STATUS, 32'h0, q);
        chk(q[4:0] === 5'h03 && irq === 1'b0, "status or mask");
        bus(1'b1, pin_pkg::OFS_IRQ_MASK, 32'h3, q);
        tick(2);
        chk(irq === 1'b1, "unmasked irq low");
        bus(1'b1, pin_pkg::OFS_IRQ_STATUS, 32'h3, q);
        tick(2);
        chk(irq === 1'b0, "status not cleared");
    endtask
    task t_timer;
        logic [31:0] q;
        int          n;
        n = 0;
        expire <= 1'b1;
        tick(1);
        expire <= 1'b0;
        repeat (8)
        begin
            @(posedge clk);
            if (tout === 1'b1)
                n++;
        end
        chk(n == 4, "pulse length");
        bus(1'b0, pin_pkg::OFS_IRQ_STATUS, 32'h0, q);
        chk(q[4] === 1'b1, "timer status");
        bus(1'b1, 5'h1c, 32'hffffffff, q);
        bus(1'b0, 5'h1c, 32'h0, q);
        chk(q === pin_pkg::UNMAPPED_READ, "unmapped read");
    endtask
    task t_reboot;
        logic [31:0] q;
        reset_n <= 1'b0;
        boot <= 1'b1;
        strap <= 1'b1;
        tick(4);
        reset_n <= 1'b1;
        tick(3);
        ia <= 4'h4;
        tick(6);
        chk(cir === 4'h4, "interrupt boot kept requests off");
        ia <= 4'h0;
        bus(1'b0, pin_pkg::OFS_STRAP, 32'h0, q);
        chk(q === 32'h3, "straps latched");
    endtask
    initial
    begin
        tick(16);
        reset_n <= 1'b1;
        tick(2);
        t_defaults();
        t_flags();
        t_irq();
        t_timer();
        t_reboot();
        end_sim();
    end
endmodule
